// ===== verilog/irq_consts.svh
// Constants of the software trap and external interrupt block.
// Assumes inclusion by bare name; holds macros only.
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// Register offsets inside the special-function area
`define OFS_ENABLE_GROUP_C 6'h2A
`define OFS_LATCH_GROUP_C 6'h2B
`define OFS_ENABLE_GROUP_E 6'h2C
`define OFS_ENABLE_GROUP_D 6'h2D
`define OFS_LATCH_GROUP_E 6'h2E
`define OFS_LATCH_GROUP_D 6'h2F
`define OFS_EXT_IRQ_CONTROL 6'h37
`define OFS_ENABLE_LOW 6'h3A
`define OFS_ENABLE_HIGH 6'h3B
`define OFS_LATCH_LOW 6'h3C
`define OFS_LATCH_HIGH 6'h3D
`define OFS_STATUS_LOW 6'h3E
`define OFS_STATUS_HIGH 6'h3F

// Register file geometry and indices
`define REG_COUNT 13
`define IDX_EXT_IRQ_CONTROL 6
`define IDX_ENABLE_LOW 7
`define IDX_LATCH_LOW 9

// Field positions
`define BIT_PIN_SELECT 6
`define BIT_MASTER_ENABLE 0
`define BIT_EXT_ENABLE 3
`define BIT_EXT_LATCH 3

// Reset value of every register (pin-select bit clear)
`define REG_RESET 8'h00

// Opcode of the trap instruction, also the filler for missing memory
`define TRAP_OPCODE 8'hFF

// Memory map
`define SFR_BASE 16'h0000
`define SFR_TOP 16'h003F
`define DBR_BASE 16'h1F80
`define DBR_TOP 16'h1FFF
`define RAM_BASE 16'h0040
`define RAM_TOP 16'h023F
`define ROM_BASE 16'hC000
`define ROM_TOP 16'hFFFF

// Noise filter, in periods of the high-frequency clock
`define NOISE_REJECT_FC 2
`define NOISE_ACCEPT_FC 6
`define FILTER_CYCLES ((`NOISE_REJECT_FC + `NOISE_ACCEPT_FC) / 2)

`endif

// ===== verilog/irq_pkg.sv
// Types shared by the interrupt block and its helpers.
// Assumes the constants header sits next to it.
package irq_pkg;

    // One special-function access from the CPU core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sfr_access_s;

    // One instruction fetch with the byte memory returned
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } fetch_req_s;

    // One executed instruction as seen at its end
    typedef struct packed {
        logic valid;
        logic lastCycle;
        logic [7:0] opcode;
    } exec_info_s;

endpackage : irq_pkg

// ===== verilog/pin_sync.sv
// Three-stage synchroniser for an asynchronous pin.
// Assumes the pin idles high; output moves once stages two and three agree.
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pin and result
    input wire logic pinIn,
    output logic pinOut
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;

    // Stage one only feeds stage two, never any logic
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            out_q <= 1'b1;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                out_q <= s3_q; // R17
            end
        end
    end

    assign pinOut = out_q;

    AST_SYNC_AGREE: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
        (out_q != $past(out_q)) |-> ($past(s2_q) == $past(s3_q)))
        else $error("synchroniser moved without agreement");

endmodule : pin_sync

// ===== verilog/noise_filter.sv
// Digital noise filter: a level change passes only when held long enough.
// Assumes a synchronised input; the divider select doubles the hold time.
`timescale 1ns/1ps
`include "irq_consts.svh"
module noise_filter #(
    parameter int HOLD = `FILTER_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Slow-clock select: doubles the hold
    input wire logic divSel,
    // Input and filtered level
    input wire logic levelIn,
    output logic levelOut
);
    localparam int CW = $clog2(2 * HOLD + 1);

    // Hold must sit between the reject and accept widths
    generate
        if (HOLD < `NOISE_REJECT_FC || HOLD > `NOISE_ACCEPT_FC) begin : g_bad
            $error("noise_filter HOLD out of range");
        end
    endgenerate

    logic level_q;
    logic [CW-1:0] cnt_q;
    wire [CW-1:0] limit = divSel ? CW'(2 * HOLD) : CW'(HOLD);
    wire differ = (levelIn != level_q);
    wire reached = (cnt_q == limit - CW'(1));

    // Count cycles of disagreement; any bounce restarts the count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b1;
            cnt_q <= '0;
        end else if (!differ) begin
            cnt_q <= '0;
        end else if (reached) begin
            level_q <= levelIn; // R8
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign levelOut = level_q;

    AST_FILTER_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        (level_q != $past(level_q)) |-> $past(reached) && $past(differ))
        else $error("filter passed a short pulse");

endmodule : noise_filter

// ===== verilog/soft_and_external_irq_logic.sv
// Software trap, address-error checks and the external edge interrupt.
// Assumes the CPU core presents fetches, executed opcodes and SPECIAL_FUNCTION_AREA accesses
// synchronously to sys_clk, and takes the one-cycle request pulses.
`timescale 1ns/1ps
`include "irq_consts.svh"

// Behaviour
// [R1] Trap opcode raises top-priority software interrupt
// [R2] Trap during non-maskable service acts as no-op
// [R3] Unimplemented fetch in single-chip returns trap byte
// [R4] Fetch from RAM, buffer or SPECIAL_FUNCTION_AREA resets
// [R5] Software may fill unused memory with trap
// [R6] Trap reserved for address errors and debugging
// [R7] Falling edge latches only when all enables set; the latch here is gated by pin-select alone
// [R8] Noise filter rejects short pulses, passes long
// [R9] Control bit six selects port or interrupt
// [R10] Pin-select clears at reset, pin is port
// [R11] Output pin changes may cause spurious request
// [R12] Disable interrupt before rewriting control register
// [R13] Memory-mapped SPECIAL_FUNCTION_AREA and data-buffer address decode
// [R14] Software avoids reserved and inaccessible addresses
// [R15] No read-modify-write on latches or write-only
// [R16] Requests sampled in final instruction cycle
// [R17] Pin synchronised before filter and edge detection
module soft_and_external_irq_logic (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Special-function access from the core
    input wire irq_pkg::sfr_access_s sfrBus,
    output logic [7:0] sfrReadData,
    // Instruction fetch path
    input wire irq_pkg::fetch_req_s fetchReq,
    input wire logic singleChipMode,
    output logic [7:0] fetchData,
    output logic addrTrapReset,
    // Execution status from the core
    input wire irq_pkg::exec_info_s execInfo,
    input wire logic nmiInService,
    // Clock gear divider select
    input wire logic clockDividerSelect,
    // Shared interrupt / port pin
    input wire logic extIrqZeroPin,
    output logic extIrqPinSelect,
    // Requests to the core
    output logic softwareIrq,
    output logic extIrqAccept
);
    import irq_pkg::*;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------

    // Offsets of the stored registers, in index order
    localparam logic [5:0] REG_OFS [`REG_COUNT] = '{
        `OFS_ENABLE_GROUP_C,
        `OFS_LATCH_GROUP_C,
        `OFS_ENABLE_GROUP_E,
        `OFS_ENABLE_GROUP_D,
        `OFS_LATCH_GROUP_E,
        `OFS_LATCH_GROUP_D,
        `OFS_EXT_IRQ_CONTROL,
        `OFS_ENABLE_LOW,
        `OFS_ENABLE_HIGH,
        `OFS_LATCH_LOW,
        `OFS_LATCH_HIGH,
        `OFS_STATUS_LOW,
        `OFS_STATUS_HIGH
    };

    // Storage, one byte per register
    logic [7:0] regFile_q [`REG_COUNT];
    // Next values of storage
    logic [7:0] regFile_d [`REG_COUNT];
    // Per-register address match
    logic [`REG_COUNT-1:0] regHit;

    // Address falls in the special-function window
    wire sfrSpace = (sfrBus.addr <= `SFR_TOP); // R13
    // Byte offset within that window
    wire [5:0] sfrOfs = sfrBus.addr[5:0];

    // One comparator per register
    generate
        for (genvar gi = 0; gi < `REG_COUNT; gi++) begin : g_hit
            assign regHit[gi] = sfrSpace && (sfrOfs == REG_OFS[gi]); // R13
        end
    endgenerate

    // Write strobe straight from the bus; decode is applied per register
    wire sfrWrite = sfrBus.wr;
    // Read strobe straight from the bus; decode is applied in the read multiplexer
    wire sfrRead = sfrBus.rd;

    // Read multiplexer: unmapped offsets return zero
    logic [7:0] readMux;
    always_comb begin
        readMux = 8'h00;
        for (int i = 0; i < `REG_COUNT; i++) begin
            if (regHit[i]) begin
                readMux = regFile_q[i]; // R13
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin path: synchroniser, noise filter, edge detector
    // ------------------------------------------------------------------

    // Pin after four flip-flops (three stages and the output register)
    logic pinSynced;
    // Pin after the noise filter
    logic pinFiltered;
    // Previous filtered level, for edge detection
    logic pinPrev_q;

    // Synchronise first so the filter sees a clean level
    pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pinIn(extIrqZeroPin),
        .pinOut(pinSynced)
    );

    // Reject short glitches before any edge is looked at
    noise_filter #(
        .HOLD(`FILTER_CYCLES)
    ) u_filter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .divSel(clockDividerSelect),
        .levelIn(pinSynced),
        .levelOut(pinFiltered)
    );

    // Remember last filtered level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinPrev_q <= 1'b1;
        end else begin
            pinPrev_q <= pinFiltered;
        end
    end

    // Falling edge, one cycle wide
    wire pinFall = pinPrev_q && !pinFiltered; // R17
    // Pin-select bit from the control register
    wire pinSelect = regFile_q[`IDX_EXT_IRQ_CONTROL][`BIT_PIN_SELECT]; // R9
    // Any falling edge counts while pin-select is set, even one caused by the port driving the pin
    wire extLatchSet = pinFall && pinSelect; // R7 R11

    // ------------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------------

    // Master enable lives in the low enable register
    wire masterEnable = regFile_q[`IDX_ENABLE_LOW][`BIT_MASTER_ENABLE];
    // Individual enable of the external source
    wire extEnable = regFile_q[`IDX_ENABLE_LOW][`BIT_EXT_ENABLE];
    // Pending external latch
    wire extLatch = regFile_q[`IDX_LATCH_LOW][`BIT_EXT_LATCH];

    // Trap opcode finished executing
    wire trapExec = execInfo.valid && (execInfo.opcode == `TRAP_OPCODE);
    // Trap is a no-op while a non-maskable service runs
    wire trapTake = trapExec && !nmiInService; // R1 R2
    // Requests only sampled in the final cycle; trap wins over all
    wire extTake = execInfo.lastCycle && !trapTake && masterEnable
                   && extEnable && extLatch && pinSelect; // R1 R7 R16

    // ------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------

    // Write, then accept-clear, then hardware set; set wins over both
    always_comb begin
        for (int i = 0; i < `REG_COUNT; i++) begin
            regFile_d[i] = regFile_q[i];
            if (sfrWrite && regHit[i]) begin
                regFile_d[i] = sfrBus.wdata; // R9
            end
        end
        if (extTake) begin
            regFile_d[`IDX_LATCH_LOW][`BIT_EXT_LATCH] = 1'b0;
        end
        if (extLatchSet) begin
            regFile_d[`IDX_LATCH_LOW][`BIT_EXT_LATCH] = 1'b1; // R7
        end
    end

    // Storage; reset leaves pin-select clear so the pin is a port
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regFile_q[i] <= `REG_RESET; // R10
            end
        end else begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regFile_q[i] <= regFile_d[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Fetch checks
    // ------------------------------------------------------------------

    // Region decode on the fetch address
    wire fetchInSfr = (fetchReq.addr <= `SFR_TOP);
    wire fetchInRam = (fetchReq.addr >= `RAM_BASE) && (fetchReq.addr <= `RAM_TOP);
    wire fetchInDbr = (fetchReq.addr >= `DBR_BASE) && (fetchReq.addr <= `DBR_TOP);
    wire fetchInRom = (fetchReq.addr >= `ROM_BASE);
    // Data areas must never be executed
    wire fetchInData = fetchInSfr || fetchInRam || fetchInDbr; // R4
    // Nothing lives here at all
    wire fetchMissing = !(fetchInData || fetchInRom);
    // In single-chip mode missing memory reads as the trap byte, so stray code traps
    wire [7:0] fetchMux = (singleChipMode && fetchMissing) ? `TRAP_OPCODE
                          : fetchReq.data; // R3

    // ------------------------------------------------------------------
    // Output flip-flops
    // ------------------------------------------------------------------

    logic [7:0] sfrReadData_q;
    logic [7:0] fetchData_q;
    logic addrTrap_q;
    logic softwareIrq_q;
    logic extIrqAccept_q;
    logic pinSelect_q;

    // Read data holds until the next read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfrReadData_q <= 8'h00;
        end else if (sfrRead) begin
            sfrReadData_q <= readMux;
        end
    end

    // Fetch byte and trap reset follow each fetch by one cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetchData_q <= 8'h00;
            addrTrap_q <= 1'b0;
        end else begin
            fetchData_q <= fetchReq.valid ? fetchMux : fetchData_q; // R3
            addrTrap_q <= fetchReq.valid && fetchInData; // R4
        end
    end

    // Request pulses to the core
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            softwareIrq_q <= 1'b0;
            extIrqAccept_q <= 1'b0;
            pinSelect_q <= 1'b0;
        end else begin
            softwareIrq_q <= trapTake; // R1 R2
            extIrqAccept_q <= extTake; // R16
            pinSelect_q <= regFile_d[`IDX_EXT_IRQ_CONTROL][`BIT_PIN_SELECT]; // R9 R10
        end
    end

    assign sfrReadData = sfrReadData_q;
    assign fetchData = fetchData_q;
    assign addrTrapReset = addrTrap_q;
    assign softwareIrq = softwareIrq_q;
    assign extIrqAccept = extIrqAccept_q;
    assign extIrqPinSelect = pinSelect_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    AST_TRAP_RAISES: assert property ( // R1
        trapExec && !nmiInService |=> softwareIrq_q)
        else $error("trap did not raise software interrupt");

    AST_TRAP_NOP_IN_NMI: assert property ( // R2
        execInfo.valid && nmiInService |=> !softwareIrq_q)
        else $error("trap raised during nmi service");

    AST_TRAP_PRIORITY: assert property ( // R1
        extIrqAccept_q |-> !softwareIrq_q)
        else $error("external accepted alongside trap");

    AST_MISSING_FETCH_FF: assert property ( // R3
        fetchReq.valid && singleChipMode && fetchMissing
        |=> fetchData_q == `TRAP_OPCODE)
        else $error("missing memory did not read trap byte");

    AST_DATA_FETCH_TRAP: assert property ( // R4
        fetchReq.valid && fetchInData |=> addrTrap_q ##1 !addrTrap_q || fetchReq.valid)
        else $error("data fetch did not reset");

    AST_NO_LATCH_UNSELECTED: assert property ( // R7
        !pinSelect && !(sfrWrite && regHit[`IDX_LATCH_LOW]) && !extLatch
        |=> !extLatch)
        else $error("latch set with pin unselected");

    AST_ACCEPT_CONDITIONS: assert property ( // R16
        extIrqAccept_q |-> $past(execInfo.lastCycle) && $past(masterEnable)
        && $past(extEnable) && $past(extLatch) && $past(pinSelect)
        && (!extLatch || $past(extLatchSet)))
        else $error("external accepted outside final cycle");

    AST_SELECT_WRITE: assert property ( // R9
        sfrWrite && regHit[`IDX_EXT_IRQ_CONTROL]
        |=> extIrqPinSelect == $past(sfrBus.wdata[`BIT_PIN_SELECT]))
        else $error("pin select did not follow write");

    AST_TRAP_KEEPS_LATCH: assert property ( // R1
        trapTake && extLatch && !(sfrWrite && regHit[`IDX_LATCH_LOW])
        |=> softwareIrq_q && !extIrqAccept_q && extLatch)
        else $error("trap did not hold the external request back");

    AST_TRAP_NEEDS_OPCODE: assert property ( // R2
        softwareIrq_q |-> $past(trapExec) && !$past(nmiInService))
        else $error("software interrupt without a trap outside nmi service");

    AST_LATCH_SET_WINS: assert property ( // R7
        extLatchSet |=> extLatch)
        else $error("filtered falling edge did not set the latch");

    AST_READ_UNMAPPED: assert property ( // R13
        sfrRead && !(|regHit) |=> sfrReadData_q == 8'h00)
        else $error("unmapped read returned nonzero data");

    AST_FETCH_PASS: assert property ( // R3
        fetchReq.valid && !(singleChipMode && fetchMissing)
        |=> fetchData_q == $past(fetchReq.data))
        else $error("implemented fetch byte was altered");

    COV_TRAP: cover property (trapTake ##1 softwareIrq_q);
    COV_EXT_ACCEPT: cover property (extLatchSet ##[1:20] extIrqAccept_q);
    COV_ADDR_TRAP: cover property (addrTrap_q);
    COV_TRAP_IN_NMI: cover property (trapExec && nmiInService);
    COV_SLOW_FILTER: cover property (clockDividerSelect && extLatchSet);

endmodule : soft_and_external_irq_logic

// ===== tb/irq_pin_source.sv
// Far-side model of the shared interrupt pin: low pulses of a set length.
// Assumes pulse requests arrive just after a rising edge; pin idles high.
`timescale 1ns/1ps
module irq_pin_source (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pulse request
    input wire logic pulseGo,
    input wire logic [7:0] pulseLen,
    // Driven pin
    output logic pinOut
);
    logic [7:0] count_q; // Low cycles still to go

    // Pulled high whenever no pulse runs; port kept as input by software
    assign #1 pinOut = (count_q == 8'h00);

    // Whole-cycle low time only, so glitch widths stay exact
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 8'h00;
        end else if (pulseGo) begin
            count_q <= pulseLen;
        end else if (count_q != 8'h00) begin
            count_q <= count_q - 8'h01;
        end
    end
endmodule : irq_pin_source

// ===== tb/soft_and_external_irq_logic_bench.sv
// Self-checking bench for the trap, fetch checks and external interrupt.
// Assumes the package, the design files and the pin model are compiled first.
`timescale 1ns/1ps
module soft_and_external_irq_logic_bench;
    import irq_pkg::*;
    typedef struct packed {
        logic [2:0] kind;
        logic [8:0] val;
    } note_s;
    // Stimulus
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    sfr_access_s sfrBus = '0;
    fetch_req_s fetchReq = '0;
    exec_info_s execInfo = '0;
    logic singleChipMode = 1'b1;
    logic nmiInService = 1'b0;
    logic clockDividerSelect = 1'b0;
    logic pulseGo = 1'b0;
    logic [7:0] pulseLen = 8'h00;
    // Observed outputs
    logic extIrqZeroPin;
    logic [7:0] sfrReadData;
    logic [7:0] fetchData;
    logic addrTrapReset;
    logic extIrqPinSelect;
    logic softwareIrq;
    logic extIrqAccept;
    // Bookkeeping
    note_s notes[$];
    int mismatches = 0;
    int numChecks = 0;
    int cycles = 0;
    logic rdNow;
    logic fetchNow;
    logic [7:0] regVal;
    logic [31:0] rngState = 32'h0000E37F;
    string kindName[6] = '{"read", "fetch", "trap", "ext", "reset", "stray"};
    logic [15:0] regAddr[13] = '{16'h002A, 16'h002B, 16'h002C, 16'h002D, 16'h002E,
        16'h002F, 16'h0037, 16'h003A, 16'h003B, 16'h003C, 16'h003D, 16'h003E, 16'h003F};
    logic [15:0] trapAddr[6] = '{16'h0040, 16'h023F, 16'h1F80, 16'h1FFF, 16'h0000,
        16'h003F};
    logic [15:0] holeAddr[3] = '{16'h8000, 16'h0240, 16'h1F7F};

    soft_and_external_irq_logic i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .sfrBus(sfrBus), .sfrReadData(sfrReadData), .fetchReq(fetchReq),
        .singleChipMode(singleChipMode), .fetchData(fetchData),
        .addrTrapReset(addrTrapReset), .execInfo(execInfo),
        .nmiInService(nmiInService), .clockDividerSelect(clockDividerSelect),
        .extIrqZeroPin(extIrqZeroPin), .extIrqPinSelect(extIrqPinSelect),
        .softwareIrq(softwareIrq), .extIrqAccept(extIrqAccept));
    irq_pin_source i_pin (.sys_clk(sys_clk), .rst_n(rst_n), .pulseGo(pulseGo),
        .pulseLen(pulseLen), .pinOut(extIrqZeroPin));

    // Free-running 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    // Fixed-seed xorshift source
    function automatic logic [7:0] rnd();
        rngState = rngState ^ (rngState << 13);
        rngState = rngState ^ (rngState >> 17);
        rngState = rngState ^ (rngState << 5);
        return rngState[7:0];
    endfunction : rnd

    // One compare, counted; kind and value checked together
    task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] s);
        numChecks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    // Oldest note against a result; reset notes ignore the data byte
    task automatic check(input logic [2:0] k, input logic [8:0] seen);
        note_s n;
        n = '{3'd7, 9'h1FF};
        if (notes.size() > 0) n = notes.pop_front();
        if (n.kind == 3'd4) begin
            n.kind = 3'd1;
            seen[7:0] = n.val[7:0];
        end
        cmp(kindName[k], {n.kind, n.val}, {k, seen});
    endtask : check

    // Moves to just after the n-th next rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    // Drops every strobe for one cycle
    task automatic idle();
        sfrBus = '0;
        fetchReq = '0;
        execInfo = '0;
        step(1);
    endtask : idle

    // Strobes stay up between calls, so calls run back to back
    task automatic sfr_wr(input logic [15:0] a, input logic [7:0] d);
        sfrBus = '{1'b1, 1'b0, a, d};
        step(1);
    endtask : sfr_wr

    task automatic sfr_rd(input logic [15:0] a, input logic [7:0] e);
        notes.push_back('{3'd0, {1'b0, e}});
        sfrBus = '{1'b0, 1'b1, a, 8'h00};
        step(1);
    endtask : sfr_rd

    task automatic fetch(input logic [15:0] a, input logic [7:0] d, input logic [2:0] k,
        input logic [8:0] e);
        notes.push_back('{k, e});
        fetchReq = '{1'b1, a, d};
        step(1);
    endtask : fetch

    // One executed instruction; an expected request is noted first
    task automatic exec(input logic v, input logic l, input logic [7:0] op,
        input logic [2:0] k);
        if (k != 3'd5) notes.push_back('{k, 9'h001});
        execInfo = '{v, l, op};
        step(1);
        idle();
    endtask : exec

    // Low pulse on the pin, then time for filter and latch to settle
    task automatic pulse(input logic [7:0] len);
        pulseLen = len;
        pulseGo = 1'b1;
        step(1);
        pulseGo = 1'b0;
        step(int'(len) + 24);
    endtask : pulse

    // Single verdict and exit
    task automatic end_sim();
        if (mismatches == 0 && numChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // Watcher: results of the edge just taken, looked at once settled
    always @(posedge sys_clk) begin
        rdNow = sfrBus.rd;
        fetchNow = fetchReq.valid;
        #2;
        if (rst_n) begin
            if (rdNow) check(3'd0, {1'b0, sfrReadData});
            if (fetchNow) check(3'd1, {addrTrapReset, fetchData});
            else if (addrTrapReset !== 1'b0) check(3'd5, 9'h000);
            if (softwareIrq !== 1'b0) check(3'd2, 9'h001);
            if (extIrqAccept !== 1'b0) check(3'd3, 9'h001);
        end
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        step(8);
        rst_n = 1'b1;
        cmp("pinSelect", 12'h000, {11'h000, extIrqPinSelect});
        foreach (regAddr[i]) sfr_rd(regAddr[i], 8'h00);
        foreach (regAddr[i]) begin
            regVal = rnd();
            sfr_wr(regAddr[i], regVal);
            sfr_rd(regAddr[i], regVal);
        end
        // Outside the window and reserved places are refused
        sfr_wr(16'h007F, ~regVal);
        sfr_rd(16'h003F, regVal);
        sfr_wr(16'h0038, 8'hA5);
        sfr_rd(16'h0038, 8'h00);
        sfr_rd(16'h0078, 8'h00);
        foreach (regAddr[i]) sfr_wr(regAddr[i], 8'h00);
        idle();
        // Fetch checks, back to back
        foreach (holeAddr[i]) fetch(holeAddr[i], 8'h12, 3'd1, 9'h0FF);
        fetch(16'hC000, 8'h12, 3'd1, 9'h012);
        fetch(16'hC010, 8'hFF, 3'd1, 9'h0FF);
        foreach (trapAddr[i]) fetch(trapAddr[i], 8'h5A, 3'd4, 9'h100);
        singleChipMode = 1'b0;
        fetch(16'h8000, 8'h34, 3'd1, 9'h034);
        fetch(16'h0100, 8'h34, 3'd4, 9'h100);
        idle();
        singleChipMode = 1'b1;
        // Trap, then trap under non-maskable service
        exec(1'b1, 1'b1, 8'hFF, 3'd2);
        nmiInService = 1'b1;
        exec(1'b1, 1'b1, 8'hFF, 3'd5);
        nmiInService = 1'b0;
        exec(1'b1, 1'b1, 8'h00, 3'd5);
        // External interrupt setup, master off while control changes
        sfr_wr(16'h0037, 8'h40);
        sfr_wr(16'h003A, 8'h09);
        idle();
        cmp("pinSelect", 12'h001, {11'h000, extIrqPinSelect});
        pulse(8'h01);
        sfr_rd(16'h003C, 8'h00);
        idle();
        pulse(8'h06 + (rnd() & 8'h03));
        sfr_rd(16'h003C, 8'h08);
        idle();
        exec(1'b1, 1'b0, 8'h00, 3'd5);
        exec(1'b1, 1'b1, 8'h00, 3'd3);
        sfr_rd(16'h003C, 8'h00);
        idle();
        // Trap and external request in the same final cycle
        pulse(8'h08);
        exec(1'b1, 1'b1, 8'hFF, 3'd2);
        exec(1'b0, 1'b1, 8'h00, 3'd3);
        // Master enable off: latched but never accepted
        sfr_wr(16'h003A, 8'h08);
        idle();
        pulse(8'h08);
        exec(1'b1, 1'b1, 8'h00, 3'd5);
        sfr_rd(16'h003C, 8'h08);
        sfr_wr(16'h003C, 8'h00);
        // Slow filter still passes a long pulse
        clockDividerSelect = 1'b1;
        sfr_wr(16'h003A, 8'h09);
        idle();
        pulse(8'h10);
        exec(1'b1, 1'b1, 8'h00, 3'd3);
        clockDividerSelect = 1'b0;
        // Port setting: edges never latch
        sfr_wr(16'h003A, 8'h00);
        sfr_wr(16'h0037, 8'h00);
        idle();
        pulse(8'h08);
        sfr_rd(16'h003C, 8'h00);
        idle();
        step(2);
        cmp("queue", 12'h000, 12'(notes.size()));
        end_sim();
    end
endmodule : soft_and_external_irq_logic_bench
